// File: pkg/sdram_cmd_pkg.sv
// shared constants, command codes and state types of the bank command logic
package sdram_cmd_pkg;
    // ----------------------------------------
    // geometry and clock
    // ----------------------------------------
    localparam int NUM_BANKS = 4;
    localparam int BANK_W = 2;
    localparam int CNT_W = 4;
    localparam int CLK_PERIOD_NS = 50;
    // ----------------------------------------
    // timing in ns, converted to whole cycles
    // ----------------------------------------
    localparam int ROW_PRECHARGE_TIME_NS = 20;
    localparam int ROW_TO_COLUMN_DELAY_NS = 20;
    localparam int REFRESH_CYCLE_TIME_NS = 70;
    localparam int MODE_REGISTER_DELAY_NS = 100;
    localparam int SELF_REFRESH_EXIT_TIME_NS = 80;
    // least times: round up, never below one cycle
    function automatic int min_cycles(input int t_ns);
        int c;
        c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction
    localparam int READ_LATENCY = 2;
    localparam int BURST_LEN = 4;
    localparam int WRITE_RECOVERY_CYC = 1;
    // counter loads are cycles minus one: the state lasts exactly the count
    localparam logic [CNT_W-1:0] PRE_LOAD = CNT_W'(min_cycles(ROW_PRECHARGE_TIME_NS) - 1);
    localparam logic [CNT_W-1:0] ACT_LOAD = CNT_W'(min_cycles(ROW_TO_COLUMN_DELAY_NS) - 1);
    localparam logic [CNT_W-1:0] RFC_LOAD = CNT_W'(min_cycles(REFRESH_CYCLE_TIME_NS) - 1);
    localparam logic [CNT_W-1:0] MRD_LOAD = CNT_W'(min_cycles(MODE_REGISTER_DELAY_NS) - 1);
    localparam logic [CNT_W-1:0] XSR_LOAD = CNT_W'(min_cycles(SELF_REFRESH_EXIT_TIME_NS) - 1);
    localparam logic [CNT_W-1:0] WR_PRE_LOAD =
        CNT_W'(min_cycles(ROW_PRECHARGE_TIME_NS) + WRITE_RECOVERY_CYC - 1);
    localparam logic [CNT_W-1:0] BURST_LOAD = CNT_W'(BURST_LEN - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
    // ----------------------------------------
    // commands as {select, row, column, write} strobes, all active low
    // ----------------------------------------
    localparam logic [3:0] CMD_LMR = 4'h0;
    localparam logic [3:0] CMD_REF = 4'h1;
    localparam logic [3:0] CMD_PRE = 4'h2;
    localparam logic [3:0] CMD_ACT = 4'h3;
    localparam logic [3:0] CMD_WR = 4'h4;
    localparam logic [3:0] CMD_RD = 4'h5;
    localparam logic [3:0] CMD_TERM = 4'h6;
    localparam logic [3:0] CMD_NOP = 4'h7;
    typedef enum logic [2:0] {
        B_IDLE, B_ACTIVATING, B_ROW_ACTIVE, B_READING,
        B_WRITING, B_READ_AP, B_WRITE_AP, B_PRECHARGING
    } bank_state_t;
    typedef enum logic [2:0] {
        D_NORMAL, D_REFRESH, D_MODE, D_PRE_ALL, D_SELF_REF, D_SR_EXIT
    } dev_state_t;
endpackage

// File: hdl/sdram_bank_fsm.sv
// state machine and down-counter of one bank
`timescale 1ns/100ps
`default_nettype none
module sdram_bank_fsm
    import sdram_cmd_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic act_req,
    input wire logic col_req,
    input wire logic col_write,
    input wire logic ap,
    input wire logic pre_req,
    input wire logic burst_end,
    output bank_state_t state,
    output logic idle,
    output logic col_ok
);
    bank_state_t state_r, state_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic ap_run_r, ap_run_nxt;
    wire cnt_zero = (cnt_r == CNT_ZERO);
    wire [CNT_W-1:0] cnt_dec = cnt_r - CNT_ONE;
    // ----------------------------------------
    // status seen by the command decoder
    // ----------------------------------------
    assign state = state_r;
    assign idle = (state_r == B_IDLE);
    assign col_ok = (state_r == B_ROW_ACTIVE) || (state_r == B_READING)
                    || (state_r == B_WRITING);
    // ----------------------------------------
    // next state; busy states ignore this bank's commands
    // ----------------------------------------
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        ap_run_nxt = ap_run_r;
        unique case (state_r)
            B_IDLE: begin
                // precharge to an idle bank changes nothing
                if (act_req) begin
                    state_nxt = B_ACTIVATING;
                    cnt_nxt = ACT_LOAD;
                end
            end
            B_ACTIVATING, B_PRECHARGING: begin
                if (cnt_zero) begin
                    state_nxt = (state_r == B_ACTIVATING) ? B_ROW_ACTIVE : B_IDLE;
                end else begin
                    cnt_nxt = cnt_dec;
                end
            end
            B_ROW_ACTIVE, B_READING, B_WRITING: begin
                if (pre_req) begin
                    state_nxt = B_PRECHARGING;
                    cnt_nxt = PRE_LOAD;
                end else if (col_req) begin
                    if (col_write) begin
                        state_nxt = ap ? B_WRITE_AP : B_WRITING;
                    end else begin
                        state_nxt = ap ? B_READ_AP : B_READING;
                    end
                    ap_run_nxt = 1'b0;
                end else if (burst_end && (state_r != B_ROW_ACTIVE)) begin
                    state_nxt = B_ROW_ACTIVE;
                end
            end
            B_READ_AP, B_WRITE_AP: begin
                // burst end or interruption starts the hidden precharge
                if (!ap_run_r) begin
                    if (burst_end) begin
                        ap_run_nxt = 1'b1;
                        cnt_nxt = (state_r == B_READ_AP) ? PRE_LOAD : WR_PRE_LOAD;
                    end
                end else if (cnt_zero) begin
                    state_nxt = B_IDLE;
                    ap_run_nxt = 1'b0;
                end else begin
                    cnt_nxt = cnt_dec;
                end
            end
        endcase
    end
    // ----------------------------------------
    // one state register and one counter per bank
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= B_IDLE;
            cnt_r <= CNT_ZERO;
            ap_run_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            ap_run_r <= ap_run_nxt;
        end
    end
    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence act_taken;
        act_req && idle;
    endsequence
    a_act_opens_row: assert property (@(posedge ref_clk) disable iff (!resetn)
        act_taken |=> (state_r == B_ACTIVATING) ##[0:15] (state_r == B_ROW_ACTIVE))
        else $error("activated bank never became row active");
    a_pre_idle_noop: assert property (@(posedge ref_clk) disable iff (!resetn)
        (pre_req && idle && !act_req) |=> idle)
        else $error("precharge moved an idle bank");
    a_pre_truncates: assert property (@(posedge ref_clk) disable iff (!resetn)
        (pre_req && col_ok) |=> (state_r == B_PRECHARGING) ##[0:15] idle)
        else $error("precharge did not close the row in time");
    a_ap_stays_busy: assert property (@(posedge ref_clk) disable iff (!resetn)
        (col_req && col_ok && ap && !pre_req) |=> !idle [*2])
        else $error("auto precharge bank went idle too early");
endmodule // sdram_bank_fsm
`default_nettype wire

// File: hdl/sdram_bank_command_fsm.sv
// command decoder, device-wide states and burst tracking of a four-bank sdram
`timescale 1ns/100ps
`default_nettype none
// Contract
// - deselected cycle: no command, work continues
// - nop lets ongoing operations continue
// - active opens row, waits row-to-column delay
// - refresh and mode load need all idle
// - precharge to idle bank does nothing
// - row active accepts read, write, precharge
// - read burst accepts read, write, terminate, precharge
// - write burst accepts read, write, terminate, precharge
// - terminate stops the latest burst, any bank
// - precharging lasts row precharge time, then idle
// - read auto precharge busy until precharge done
// - write auto precharge busy until precharge done
// - refresh holds device for refresh cycle time
// - mode load holds device for mode delay
// - precharge all holds device, then idle
// - precharge all needs every bank prechargeable
// - decode only with clock enable held high
// - idle bank never blocks other banks
// - busy bank allows commands to others
// - bursting bank allows commands to others
// - interrupting read data follows after read latency
// - interrupted auto precharge burst starts precharge
// - interrupted write keeps data before the read
module sdram_bank_command_fsm
    import sdram_cmd_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clock_enable,
    input wire logic chip_select_n,
    input wire logic row_strobe_n,
    input wire logic column_strobe_n,
    input wire logic write_enable_n,
    input wire logic [BANK_W-1:0] bank_addr,
    input wire logic auto_precharge,
    output bank_state_t bank_state [NUM_BANKS],
    output logic [NUM_BANKS-1:0] bank_idle,
    output logic all_banks_idle,
    output dev_state_t device_state,
    output logic burst_active,
    output logic [BANK_W-1:0] burst_bank,
    output logic read_data_valid,
    output logic [BANK_W-1:0] read_data_bank,
    output logic write_data_take,
    output logic [BANK_W-1:0] write_data_bank
);
    // ----------------------------------------
    // declarations
    // ----------------------------------------
    dev_state_t dev_r, dev_nxt;
    logic [CNT_W-1:0] dev_cnt_r, dev_cnt_nxt;
    logic cke_prev_r;
    logic owner_v_r, owner_v_nxt;
    logic [BANK_W-1:0] owner_r, owner_nxt;
    logic [CNT_W-1:0] left_r, left_nxt;
    logic is_wr_r, is_wr_nxt;
    logic [READ_LATENCY-1:0] rd_v_r;
    logic [BANK_W-1:0] rd_b_r [READ_LATENCY];
    logic [NUM_BANKS-1:0] col_ok;
    logic [NUM_BANKS-1:0] act_req;
    logic [NUM_BANKS-1:0] col_req;
    logic [NUM_BANKS-1:0] pre_req;
    logic [NUM_BANKS-1:0] burst_end;
    // ----------------------------------------
    // command decode
    // ----------------------------------------
    wire [3:0] code = {chip_select_n, row_strobe_n, column_strobe_n, write_enable_n};
    // decoding needs clock enable on this and the previous edge
    wire cke_ok = cke_prev_r && clock_enable;
    wire normal = (dev_r == D_NORMAL);
    // a high select is an inhibit: nothing below can fire
    wire cmd_valid = !chip_select_n && cke_ok && normal;
    // nop matches no command code, so it only lets work continue
    wire is_act = cmd_valid && (code == CMD_ACT);
    wire is_rd = cmd_valid && (code == CMD_RD);
    wire is_wr = cmd_valid && (code == CMD_WR);
    wire is_pre = cmd_valid && (code == CMD_PRE);
    wire is_term = cmd_valid && (code == CMD_TERM);
    wire is_ref = cmd_valid && (code == CMD_REF);
    wire is_lmr = cmd_valid && (code == CMD_LMR);
    wire [NUM_BANKS-1:0] sel = NUM_BANKS'(1) << bank_addr;
    // ----------------------------------------
    // device-wide commands
    // ----------------------------------------
    assign all_banks_idle = &bank_idle;
    // refresh and mode load are dropped unless every bank rests
    wire ref_go = is_ref && all_banks_idle;
    wire lmr_go = is_lmr && all_banks_idle;
    // precharge all only when no bank is mid activation or auto precharge
    wire pre_all_ok = &(bank_idle | col_ok);
    wire pre_all_go = is_pre && auto_precharge && pre_all_ok;
    wire sr_entry = !chip_select_n && (code == CMD_REF) && cke_prev_r
                    && !clock_enable && normal && all_banks_idle;
    wire cke_rise = !cke_prev_r && clock_enable;
    wire dev_zero = (dev_cnt_r == CNT_ZERO);
    // ----------------------------------------
    // per-bank requests; each bank judges its own state
    // ----------------------------------------
    // a request other than precharge all is routed to one bank only, so others keep working
    assign act_req = is_act ? sel : '0;
    assign pre_req = pre_all_go ? '1 : ((is_pre && !auto_precharge) ? sel : '0);
    wire col_go = (is_rd || is_wr) && |(sel & col_ok);
    assign col_req = col_go ? sel : '0;
    // ----------------------------------------
    // burst tracking: one data path, newest burst owns it
    // ----------------------------------------
    // an auto precharge owner ignores precharge, so its burst must run on to its end
    wire pre_owner = owner_v_r && pre_req[owner_r] && col_ok[owner_r];
    // terminate always hits the latest burst whatever bank it used
    wire term_go = is_term && owner_v_r;
    wire stop_now = term_go || pre_owner || col_go;
    wire cont = owner_v_r && (left_r != CNT_ZERO) && !stop_now;
    wire other_bank = col_go && (bank_addr != owner_r);
    // a burst to another bank ends the owner burst, auto precharge follows
    wire end_now = owner_v_r && ((left_r == CNT_ZERO) || term_go || other_bank);
    assign burst_end = end_now ? (NUM_BANKS'(1) << owner_r) : '0;
    // read data restarts for the new bank, seen one latency later
    wire beat_rd = (col_go && is_rd) || (cont && !is_wr_r);
    wire [BANK_W-1:0] beat_bank = col_go ? bank_addr : owner_r;
    // write data: taken with the command, dropped at an interrupting read
    assign write_data_take = (col_go && is_wr) || (cont && is_wr_r);
    assign write_data_bank = beat_bank;
    always_comb begin
        owner_nxt = owner_r;
        owner_v_nxt = owner_v_r;
        left_nxt = left_r;
        is_wr_nxt = is_wr_r;
        if (col_go) begin
            owner_nxt = bank_addr;
            owner_v_nxt = 1'b1;
            left_nxt = BURST_LOAD;
            is_wr_nxt = is_wr;
        end else if (end_now || pre_owner) begin
            owner_v_nxt = 1'b0;
        end else if (cont) begin
            left_nxt = left_r - CNT_ONE;
        end
    end
    // ----------------------------------------
    // device-wide state and busy counter
    // ----------------------------------------
    always_comb begin
        dev_nxt = dev_r;
        dev_cnt_nxt = dev_cnt_r;
        unique case (dev_r)
            D_NORMAL: begin
                if (ref_go) begin
                    dev_nxt = D_REFRESH;
                    dev_cnt_nxt = RFC_LOAD;
                end else if (lmr_go) begin
                    dev_nxt = D_MODE;
                    dev_cnt_nxt = MRD_LOAD;
                end else if (pre_all_go) begin
                    dev_nxt = D_PRE_ALL;
                    dev_cnt_nxt = PRE_LOAD;
                end else if (sr_entry) begin
                    dev_nxt = D_SELF_REF;
                end
            end
            D_SELF_REF: begin
                // leaving self refresh waits out the exit time
                if (cke_rise) begin
                    dev_nxt = D_SR_EXIT;
                    dev_cnt_nxt = XSR_LOAD;
                end
            end
            D_REFRESH, D_MODE, D_PRE_ALL, D_SR_EXIT: begin
                // all commands are ignored until the count runs out
                if (dev_zero) begin
                    dev_nxt = D_NORMAL;
                end else begin
                    dev_cnt_nxt = dev_cnt_r - CNT_ONE;
                end
            end
            default: begin
                dev_nxt = D_NORMAL;
            end
        endcase
    end
    // ----------------------------------------
    // registers
    // ----------------------------------------
    // clock enable history starts low: the first edge decodes nothing
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            dev_r <= D_NORMAL;
            dev_cnt_r <= CNT_ZERO;
            cke_prev_r <= 1'b0;
        end else begin
            dev_r <= dev_nxt;
            dev_cnt_r <= dev_cnt_nxt;
            cke_prev_r <= clock_enable;
        end
    end
    // burst owner and remaining beats
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            owner_v_r <= 1'b0;
            owner_r <= '0;
            left_r <= CNT_ZERO;
            is_wr_r <= 1'b0;
        end else begin
            owner_v_r <= owner_v_nxt;
            owner_r <= owner_nxt;
            left_r <= left_nxt;
            is_wr_r <= is_wr_nxt;
        end
    end
    // read latency pipeline; a shift keeps overlapping reads in order
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rd_v_r <= '0;
            for (int i = 0; i < READ_LATENCY; i++) begin
                rd_b_r[i] <= '0;
            end
        end else begin
            rd_v_r <= {rd_v_r[READ_LATENCY-2:0], beat_rd};
            rd_b_r[0] <= beat_bank;
            for (int i = 1; i < READ_LATENCY; i++) begin
                rd_b_r[i] <= rd_b_r[i-1];
            end
        end
    end
    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign device_state = dev_r;
    assign burst_active = owner_v_r;
    assign burst_bank = owner_r;
    assign read_data_valid = rd_v_r[READ_LATENCY-1];
    assign read_data_bank = rd_b_r[READ_LATENCY-1];
    // ----------------------------------------
    // one state machine per bank
    // ----------------------------------------
    for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
        sdram_bank_fsm u_bank (
            .ref_clk(ref_clk),
            .resetn(resetn),
            .act_req(act_req[b]),
            .col_req(col_req[b]),
            .col_write(is_wr),
            .ap(auto_precharge),
            .pre_req(pre_req[b]),
            .burst_end(burst_end[b]),
            .state(bank_state[b]),
            .idle(bank_idle[b]),
            .col_ok(col_ok[b])
        );
    end
    // ----------------------------------------
    // checks
    // ----------------------------------------
    localparam int RD_LAT_A = READ_LATENCY;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    wire any_go = is_act || col_go || is_pre || ref_go || lmr_go || term_go;
    a_inhibit_quiet: assert property (chip_select_n |-> !any_go)
        else $error("command taken while deselected");
    a_nop_quiet: assert property ((code == CMD_NOP) |-> !any_go)
        else $error("nop started a command");
    a_global_idle: assert property ((ref_go || lmr_go) |-> all_banks_idle)
        else $error("device command taken with a busy bank");
    sequence refresh_span;
        (dev_r == D_REFRESH) ##[1:16] (normal && all_banks_idle);
    endsequence
    a_refresh_span: assert property (ref_go |=> refresh_span)
        else $error("refresh did not finish with all banks idle");
    a_mode_span: assert property (lmr_go |=> (dev_r == D_MODE) ##[1:16] normal)
        else $error("mode load period did not end");
    a_pre_all_idle: assert property (pre_all_go |-> ##[1:16] (normal && all_banks_idle))
        else $error("precharge all left a bank open");
    a_cke_gate: assert property (!(cke_prev_r && clock_enable) |-> !cmd_valid)
        else $error("command decoded without clock enable history");
    a_term_stops: assert property (term_go |=> !owner_v_r && (col_go || !write_data_take))
        else $error("terminate left a burst running");
    a_read_latency: assert property ((col_go && is_rd) |-> ##RD_LAT_A
        (read_data_valid && (read_data_bank == $past(bank_addr, RD_LAT_A))))
        else $error("read data not on time for the new bank");
    a_write_cut: assert property ((col_go && is_rd && owner_v_r && is_wr_r)
        |-> !write_data_take)
        else $error("write data taken at the interrupting read");
endmodule // sdram_bank_command_fsm
`default_nettype wire

// File: sim/sdram_ctrl_model.sv
// controller stand-in that drives one command per clock onto the pins
`timescale 1ns/100ps
`default_nettype none
module sdram_ctrl_model
    import sdram_cmd_pkg::*;
(
    input wire logic ref_clk,
    output logic clock_enable,
    output logic chip_select_n,
    output logic row_strobe_n,
    output logic column_strobe_n,
    output logic write_enable_n,
    output logic [BANK_W-1:0] bank_addr,
    output logic auto_precharge
);
    // ----------------------------------------
    // bus at time zero
    // ----------------------------------------
    // clock enable rests high; issue_cke_low pulls it low for one command
    initial begin
        clock_enable = 1'b1;
        {chip_select_n, row_strobe_n, column_strobe_n, write_enable_n} = CMD_NOP;
        bank_addr = 2'h0;
        auto_precharge = 1'b0;
    end
    // ----------------------------------------
    // command tasks, entered at a falling edge
    // ----------------------------------------
    // pins change once per falling edge, so every edge carries one command
    task automatic issue(input logic [3:0] cmd, input logic [BANK_W-1:0] bank, input logic ap);
        {chip_select_n, row_strobe_n, column_strobe_n, write_enable_n} = cmd;
        bank_addr = bank;
        auto_precharge = ap;
        @(negedge ref_clk);
    endtask
    // waits are nops; the address is scrambled so a stale value never counts
    task automatic idle(input int n);
        for (int i = 0; i < n; i++) begin
            issue(CMD_NOP, ~bank_addr, ~auto_precharge);
        end
    endtask
    // that edge and the next one decode no command except a self refresh entry
    task automatic issue_cke_low(input logic [3:0] cmd);
        clock_enable = 1'b0;
        issue(cmd, 2'h0, 1'b0);
        clock_enable = 1'b1;
    endtask
endmodule // sdram_ctrl_model
`default_nettype wire

// File: sim/tb_sdram_bank_command_fsm.sv
// self-checking bench of the bank command state machine
`timescale 1ns/100ps
`default_nettype none
module tb_sdram_bank_command_fsm
    import sdram_cmd_pkg::*;
;
    logic ref_clk, resetn, clock_enable, chip_select_n, row_strobe_n;
    logic column_strobe_n, write_enable_n, auto_precharge;
    logic [BANK_W-1:0] bank_addr, burst_bank, read_data_bank, write_data_bank;
    bank_state_t bank_state [NUM_BANKS];
    logic [NUM_BANKS-1:0] bank_idle;
    logic all_banks_idle, burst_active, read_data_valid, write_data_take;
    dev_state_t device_state;
    int mismatches = 0;
    int checks_done = 0;
    sdram_ctrl_model ctrl (.ref_clk(ref_clk), .clock_enable(clock_enable),
        .chip_select_n(chip_select_n), .row_strobe_n(row_strobe_n),
        .column_strobe_n(column_strobe_n), .write_enable_n(write_enable_n),
        .bank_addr(bank_addr), .auto_precharge(auto_precharge));
    sdram_bank_command_fsm uut (.ref_clk(ref_clk), .resetn(resetn), .clock_enable(clock_enable),
        .chip_select_n(chip_select_n), .row_strobe_n(row_strobe_n),
        .column_strobe_n(column_strobe_n), .write_enable_n(write_enable_n),
        .bank_addr(bank_addr), .auto_precharge(auto_precharge), .bank_state(bank_state),
        .bank_idle(bank_idle), .all_banks_idle(all_banks_idle), .device_state(device_state),
        .burst_active(burst_active), .burst_bank(burst_bank),
        .read_data_valid(read_data_valid), .read_data_bank(read_data_bank),
        .write_data_take(write_data_take), .write_data_bank(write_data_bank));
    // ----------------------------------------
    // clock, compare and verdict
    // ----------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("mismatches=%0d checks_done=%0d", mismatches, checks_done);
        if (mismatches == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    // read walk with a deselected pattern with only the row strobe low and a nop inside it
    task automatic read_walk();
        ctrl.issue(CMD_ACT, 2'h0, 1'b0);
        chk(8'(bank_state[0]), 8'(B_ACTIVATING));
        ctrl.idle(1);
        chk(8'(bank_state[0]), 8'(B_ROW_ACTIVE));
        ctrl.issue(CMD_RD, 2'h0, 1'b0);
        chk(8'({burst_active, bank_state[0]}), 8'({1'b1, B_READING}));
        ctrl.issue(4'hb, 2'h1, 1'b1);
        chk(8'({device_state, bank_state[1]}), 8'({D_NORMAL, B_IDLE}));
        ctrl.idle(1);
        chk(8'({read_data_valid, read_data_bank}), 8'h4);
        ctrl.idle(1);
        chk(8'(bank_state[0]), 8'(B_READING));
        ctrl.idle(1);
        chk(8'({burst_active, bank_state[0]}), 8'({1'b0, B_ROW_ACTIVE}));
        ctrl.idle(1);
        chk(8'(read_data_valid), 8'h0);
    endtask
    // precharge of an idle bank changes nothing; an open bank closes
    task automatic precharge_single();
        ctrl.issue(CMD_PRE, 2'h1, 1'b0);
        chk(8'(bank_state[1]), 8'(B_IDLE));
        ctrl.issue(CMD_PRE, 2'h0, 1'b0);
        chk(8'(bank_state[0]), 8'(B_PRECHARGING));
        ctrl.idle(1);
        chk(8'(bank_state[0]), 8'(B_IDLE));
    endtask
    // write with auto precharge overlapped by an activate to another bank
    task automatic write_ap_overlap();
        ctrl.issue(CMD_ACT, 2'h2, 1'b0);
        ctrl.idle(1);
        ctrl.issue(CMD_WR, 2'h2, 1'b1);
        chk(8'(bank_state[2]), 8'(B_WRITE_AP));
        ctrl.issue(CMD_ACT, 2'h3, 1'b0);
        chk(8'(bank_state[3]), 8'(B_ACTIVATING));
        ctrl.idle(4);
        chk(8'(bank_state[2]), 8'(B_WRITE_AP));
        ctrl.idle(1);
        chk(8'({bank_state[2], bank_state[3]}), 8'({B_IDLE, B_ROW_ACTIVE}));
    endtask
    // terminate cuts the read short; refresh is refused with a row open
    task automatic terminate_and_refuse();
        ctrl.issue(CMD_RD, 2'h3, 1'b0);
        ctrl.issue(CMD_TERM, 2'h0, 1'b0);
        ctrl.idle(1);
        chk(8'({burst_active, bank_state[3]}), 8'({1'b0, B_ROW_ACTIVE}));
        ctrl.issue(CMD_REF, 2'h0, 1'b0);
        chk(8'(device_state), 8'(D_NORMAL));
    endtask
    // precharge all, then refresh and mode load hold the device two cycles
    task automatic device_wide();
        logic [3:0] cmds [2];
        dev_state_t busy [2];
        cmds = '{CMD_REF, CMD_LMR};
        busy = '{D_REFRESH, D_MODE};
        ctrl.issue(CMD_PRE, 2'h0, 1'b1);
        chk(8'({device_state, bank_state[3]}), 8'({D_PRE_ALL, B_PRECHARGING}));
        ctrl.idle(1);
        chk(8'({device_state, all_banks_idle}), 8'({D_NORMAL, 1'b1}));
        for (int i = 0; i < 2; i++) begin
            ctrl.issue(cmds[i], 2'h0, 1'b0);
            ctrl.idle(1);
            chk(8'(device_state), 8'(busy[i]));
            ctrl.idle(1);
            chk(8'({device_state, all_banks_idle}), 8'({D_NORMAL, 1'b1}));
        end
    endtask
    // read cut by a write to another bank after a mask cycle; precharge all ends it
    task automatic read_cut_by_write();
        ctrl.issue(CMD_ACT, 2'h0, 1'b0);
        ctrl.issue(CMD_ACT, 2'h1, 1'b0);
        ctrl.issue(CMD_RD, 2'h0, 1'b0);
        ctrl.idle(1);
        ctrl.issue(CMD_WR, 2'h1, 1'b0);
        ctrl.idle(1);
        chk(8'({read_data_valid, write_data_take, write_data_bank}), 8'({2'h1, 2'h1}));
        chk(8'({bank_state[0], bank_state[1]}), 8'({B_ROW_ACTIVE, B_WRITING}));
        ctrl.issue(CMD_PRE, 2'h0, 1'b1);
        ctrl.idle(1);
        chk(8'({device_state, all_banks_idle, burst_active}), 8'({D_NORMAL, 2'h2}));
    endtask
    // clock enable gating, then self refresh entry and exit
    task automatic clock_enable_gate();
        ctrl.issue_cke_low(CMD_ACT);
        ctrl.issue(CMD_ACT, 2'h0, 1'b0);
        chk(8'(bank_state[0]), 8'(B_IDLE));
        ctrl.issue_cke_low(CMD_REF);
        chk(8'(device_state), 8'(D_SELF_REF));
        ctrl.idle(2);
        chk(8'(device_state), 8'(D_SR_EXIT));
        ctrl.idle(1);
        ctrl.issue(CMD_ACT, 2'h0, 1'b0);
        chk(8'(bank_state[0]), 8'(B_ACTIVATING));
    endtask
    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        resetn = 1'b0;
        repeat (20) @(negedge ref_clk);
        resetn = 1'b1;
        ctrl.idle(3);
        chk(8'({bank_idle, device_state}), 8'({4'hf, D_NORMAL}));
        read_walk();
        precharge_single();
        write_ap_overlap();
        terminate_and_refuse();
        device_wide();
        read_cut_by_write();
        clock_enable_gate();
        complete_run();
    end
    // the sequence needs about seventy cycles; a thousand means a hang
    initial begin
        #(1000 * 50);
        mismatches++;
        complete_run();
    end
endmodule // tb_sdram_bank_command_fsm
`default_nettype wire
